// file: pkg/rco_pkg.sv
// shared constants and types for the reference clock output block
`default_nettype none
package rco_pkg;

  // register bus address width (byte address, word aligned)
  localparam int unsigned REG_ADDR_W = 4;

  // register byte offsets
  localparam logic [REG_ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFF_STATUS = 4'h4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, msb first: bit 7 down to bit 0
  typedef struct packed {
    logic on;            // bit 7, module enable
    logic pin_drive;     // bit 6, pin output enable
    logic slew;          // bit 5, slew limiting enable
    logic [1:0] duty;    // bits 4-3, high fraction in quarters
    logic [2:0] divider; // bits 2-0, power-of-two divide
  } rco_ctrl_t;

  // control value after any reset: off, slew limited, 50 percent, undivided
  localparam logic [7:0] CTRL_RESET = 8'h30;

  // duty code that forces a constant low output
  localparam logic [1:0] DUTY_ZERO = 2'h0;

  // status register layout, low bits of the word
  typedef struct packed {
    logic osc_conflict;  // bit 3, pin taken by a crystal mode
    logic cpu_clock_out_active; // bit 2, pin carries the quarter system clock
    logic pin_refclk;    // bit 1, pin carries the reference clock
    logic running;       // bit 0, divider is counting
  } rco_status_t;

  // divider counter width, enough for divide by 128
  localparam int unsigned DIV_CNT_W = 7;

  // quarter system clock generator: last count and high length
  localparam logic [1:0] FOSC4_LAST = 2'h3;
  localparam logic [1:0] FOSC4_HIGH = 2'h2;

  // what the shared pin carries, gray coded
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_REFCLK = 2'b01,
    PIN_FOSC4 = 2'b11,
    PIN_OSC = 2'b10
  } rco_pin_src_t;

endpackage
`default_nettype wire

// file: rtl/rco_divider.sv
// power-of-two divider with quarter-step duty shaping
`timescale 1ns/100ps
`default_nettype none
module rco_divider
  import rco_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic freeze,
  input wire logic restart,
  input wire logic [2:0] div_sel,
  input wire logic [1:0] duty_sel,
  output logic clk_out
);

  // last count of one output period, 2^div - 1
  function automatic logic [DIV_CNT_W-1:0] period_last(
    input logic [2:0] d
  );
    logic [7:0] p;
    p = 8'h01 << d;
    period_last = DIV_CNT_W'(p - 8'h01);
  endfunction

  // high length in cycles; zero only for duty zero, never a full period unless undivided
  function automatic logic [7:0] high_len(
    input logic [2:0] d,
    input logic [1:0] dc
  );
    logic [9:0] prod;
    logic [7:0] q;
    logic [7:0] per;
    per = 8'h01 << d;
    prod = {2'h0, per} * {8'h00, dc};
    q = prod[9:2];
    if (dc == DUTY_ZERO) begin
      high_len = 8'h00;
    end else if (d == 3'h0) begin
      high_len = 8'h01;
    end else if (q == 8'h00) begin
      high_len = 8'h01;
    end else if (q >= per) begin
      high_len = per - 8'h01;
    end else begin
      high_len = q;
    end
  endfunction

  logic [DIV_CNT_W-1:0] cnt; // position inside the period
  logic [DIV_CNT_W-1:0] next_cnt;

  // next count: wraps at the selected period
  always_comb begin
    if (!run || restart) begin
      next_cnt = '0;
    end else if (cnt >= period_last(div_sel)) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + DIV_CNT_W'(1);
    end
  end

  // counter, frozen while the system clock is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (!freeze) begin
      cnt <= next_cnt;
    end
  end

  // shaped output; holds its level when frozen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out <= 1'b0;
    end else if (!freeze) begin
      clk_out <= run && !restart &&
        ({1'b0, next_cnt} < high_len(div_sel, duty_sel));
    end
  end

endmodule
`default_nettype wire

// file: rtl/rco_top.sv
// reference clock output block with its axi4-lite register slave
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rco_top
  import rco_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // device state, same clock domain
  input wire logic sleep_active,
  input wire logic low_power_crystal_mode,
  input wire logic standard_crystal_mode,
  input wire logic high_speed_crystal_mode,
  input wire logic cpu_cpu_clock_out_disable_n,
  // shared pin and modulator feed
  output logic refclk_out_pin,
  output logic refclk_out_pin_oe_n,
  output logic refclk_slew_limit,
  output logic refclk_modulator_clk
);

  // control register and its decoded view
  logic [7:0] ctrl_q;
  rco_ctrl_t ctrl;
  // decoded reset value, so reset branches name fields, not bit positions
  localparam rco_ctrl_t CTRL_AT_RESET = rco_ctrl_t'(CTRL_RESET);
  assign ctrl = rco_ctrl_t'(ctrl_q);

  // write channel holding state
  logic aw_held; // address captured, waiting for data
  logic w_held;  // data captured, waiting for address
  logic [REG_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic do_write; // both halves present, commit this cycle

  // read channel next values
  logic next_rvalid;
  logic ar_take;

  // divider control
  logic restart;     // one-cycle restart after a field change
  logic div_clk;     // shaped clock from the divider
  logic write_ctrl;  // commit to the control register
  rco_ctrl_t wr_val; // value being written

  // pin routing
  logic osc_conflict;
  logic cpu_clock_out_active;
  rco_pin_src_t pin_src;
  logic [1:0] fosc4_cnt; // quarter system clock phase
  logic fosc4_level;
  rco_status_t status;

  // write commit decode
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_ctrl = do_write && (aw_addr_q == OFF_CONTROL) &&
    w_strb_q[0];
  assign wr_val = rco_ctrl_t'(w_data_q[7:0]);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // next state of the write channel holders and response
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    if (s_axi_bvalid) begin
      next_bvalid = !s_axi_bready;
    end else begin
      next_bvalid = do_write;
    end
  end

  // read response next state
  always_comb begin
    if (s_axi_rvalid) begin
      next_rvalid = !s_axi_rready;
    end else begin
      next_rvalid = ar_take;
    end
  end

  // write address and data capture; either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // ready flags registered, each low while its own half waits or a response is due
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        if (aw_addr_q == OFF_CONTROL) begin
          s_axi_bresp <= RESP_OKAY;
        end else if (aw_addr_q == OFF_STATUS) begin
          s_axi_bresp <= RESP_OKAY; // read-only, write dropped
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
    end
  end

  // control register; a disabled module after any reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (write_ctrl) begin
      ctrl_q <= w_data_q[7:0];
    end
  end

  // restart the divider when a shaping field changes while running;
  // trading one period of phase for clean pulse widths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart <= 1'b0;
    end else if (!sleep_active) begin
      restart <= write_ctrl && ctrl.on && wr_val.on &&
        ((wr_val.divider != ctrl.divider) ||
         (wr_val.duty != ctrl.duty));
    end
  end

  // read channel; one request at a time, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        if (s_axi_araddr == OFF_CONTROL) begin
          s_axi_rdata <= {24'h000000, ctrl_q};
          s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_araddr == OFF_STATUS) begin
          s_axi_rdata <= {28'h0000000, status};
          s_axi_rresp <= RESP_OKAY;
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // divider fed by the system clock only, whatever the oscillator mode
  rco_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl.on),
    .freeze(sleep_active),
    .restart(restart),
    .div_sel(ctrl.divider),
    .duty_sel(ctrl.duty),
    .clk_out(div_clk)
  );

  // modulator sees the divided clock regardless of pin conflicts
  assign refclk_modulator_clk = div_clk;

  // pin conflict decode
  assign osc_conflict = low_power_crystal_mode || standard_crystal_mode ||
    high_speed_crystal_mode;
  assign cpu_clock_out_active = !cpu_cpu_clock_out_disable_n;

  // pin source; crystal modes own the pin, then clock-out, then refclk
  always_comb begin
    if (osc_conflict) begin
      pin_src = PIN_OSC;
    end else if (cpu_clock_out_active) begin
      pin_src = PIN_FOSC4;
    end else if (ctrl.on && ctrl.pin_drive) begin
      pin_src = PIN_REFCLK;
    end else begin
      pin_src = PIN_IDLE;
    end
  end

  // status view of the block
  always_comb begin
    status.osc_conflict = osc_conflict;
    status.cpu_clock_out_active = cpu_clock_out_active && !osc_conflict;
    status.pin_refclk = (pin_src == PIN_REFCLK);
    status.running = ctrl.on && !sleep_active;
  end

  // quarter system clock, 2 high and 2 low, stops in sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fosc4_cnt <= '0;
    end else if (!sleep_active) begin
      fosc4_cnt <= (fosc4_cnt == FOSC4_LAST) ? 2'h0 : fosc4_cnt + 2'h1;
    end
  end
  assign fosc4_level = (fosc4_cnt < FOSC4_HIGH);

  // pin drive; a flop keeps glitches off the pin, and sleep holds it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refclk_out_pin <= 1'b0;
      refclk_out_pin_oe_n <= 1'b1;
    end else if (!sleep_active) begin
      case (pin_src)
        PIN_OSC: begin
          refclk_out_pin <= 1'b0;
          refclk_out_pin_oe_n <= 1'b1;
        end
        PIN_FOSC4: begin
          refclk_out_pin <= fosc4_level;
          refclk_out_pin_oe_n <= 1'b0;
        end
        PIN_REFCLK: begin
          refclk_out_pin <= div_clk;
          refclk_out_pin_oe_n <= 1'b0;
        end
        default: begin
          refclk_out_pin <= 1'b0;
          refclk_out_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // slew limit follows the control bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refclk_slew_limit <= CTRL_AT_RESET.slew;
    end else begin
      refclk_slew_limit <= ctrl.slew;
    end
  end

endmodule
`default_nettype wire

// file: verification/rco_top_sva.sv
// port-level checks for the reference clock block
`timescale 1ns/100ps
`default_nettype none
module rco_top_sva
  import rco_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sleep_active,
  input wire logic low_power_crystal_mode,
  input wire logic standard_crystal_mode,
  input wire logic high_speed_crystal_mode,
  input wire logic cpu_cpu_clock_out_disable_n,
  input wire logic refclk_out_pin,
  input wire logic refclk_out_pin_oe_n,
  input wire logic refclk_slew_limit,
  input wire logic refclk_modulator_clk
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin is an oscillator input in any crystal mode
  wire crys = low_power_crystal_mode | standard_crystal_mode |
    high_speed_crystal_mode;
  // quarter clock owns the pin, not frozen
  wire f4 = !crys && !cpu_cpu_clock_out_disable_n && !sleep_active;
  // reset itself must be seen, so no disable here
  reset_idle_a: assert property (disable iff (1'h0) !aresetn |=>
    refclk_out_pin_oe_n && refclk_slew_limit && !refclk_out_pin &&
    !refclk_modulator_clk) else $error("outputs not idle after reset");
  crystal_release_a: assert property ($past(crys) |->
    refclk_out_pin_oe_n) else $error("pin driven in crystal mode");
  cpu_clock_out_drive_a: assert property ($past(f4) && $past(aresetn) |->
    !refclk_out_pin_oe_n) else $error("quarter clock not driven");
  quarter_clock_a: assert property (f4[*6] |->
    refclk_out_pin == $past(refclk_out_pin, 4) &&
    refclk_out_pin != $past(refclk_out_pin, 2))
    else $error("quarter clock pattern wrong");
  sleep_hold_a: assert property ($past(sleep_active) |->
    $stable(refclk_out_pin) && $stable(refclk_modulator_clk))
    else $error("output moved in sleep");
  pin_follow_a: assert property (
    $past(!crys && cpu_cpu_clock_out_disable_n && !sleep_active) &&
    !refclk_out_pin_oe_n |-> refclk_out_pin == $past(refclk_modulator_clk))
    else $error("pin does not follow divided clock");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  aw_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read data late");
  cover property (f4[*8]);
  cover property (sleep_active[*8]);
  cover property (!refclk_out_pin_oe_n && $rose(refclk_out_pin));
endmodule
`default_nettype wire

// file: verification/rco_pin_observer.sv
// far-side load counting pin and modulator activity
`timescale 1ns/100ps
`default_nettype none
module rco_pin_observer (
  input wire logic aclk,
  input wire logic clr,
  input wire logic pin,
  input wire logic oe_n,
  input wire logic mod,
  output logic [15:0] edges,
  output logic [15:0] highs,
  output logic [15:0] mhighs
);
  logic prev; // last driven level
  // a released pin counts as low: the load sees no drive there
  always_ff @(posedge aclk) begin
    prev <= pin & !oe_n;
    if (clr) begin
      edges <= 16'h0;
      highs <= 16'h0;
      mhighs <= 16'h0;
    end else begin
      edges <= edges + 16'(pin & !oe_n & !prev);
      highs <= highs + 16'(pin & !oe_n);
      mhighs <= mhighs + 16'(mod);
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_rco_top.sv
// self-checking bench for the reference clock block
`timescale 1ns/100ps
`default_nettype none
module tb_rco_top
  import rco_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, clr = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [REG_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic sleep_active = 1'h0, cpu_cpu_clock_out_disable_n = 1'h1;
  logic low_power_crystal_mode = 1'h0, standard_crystal_mode = 1'h0;
  logic high_speed_crystal_mode = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, refclk_out_pin, refclk_out_pin_oe_n;
  logic refclk_slew_limit, refclk_modulator_clk;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] edges, highs, mhighs; // far-side counts
  int n_errors = 0, cmp_count = 0, dv, dt, p, q, m, i;
  rco_top uut (.*);
  rco_pin_observer obs (.aclk(aclk), .clr(clr), .pin(refclk_out_pin),
    .oe_n(refclk_out_pin_oe_n), .mod(refclk_modulator_clk),
    .edges(edges), .highs(highs), .mhighs(mhighs));
  // 50 ns period
  initial begin
    forever #25 aclk = ~aclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a wait that used up its bound ends the run
  task bound;
    if (i >= 64) begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  // aw and w offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic aw_done; // address half taken
    logic w_done;  // data half taken
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'h1;
    i = 0;
    // each half may be taken at its own edge, in either order
    do begin
      @(posedge aclk);
      i++;
      if (s_axi_awready && !aw_done) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !w_done) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end while (!(aw_done && w_done) && i < 64);
    bound;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (!s_axi_bvalid && i < 64);
    bound;
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (!s_axi_arready && i < 64);
    bound;
    s_axi_arvalid <= 1'h0;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (!s_axi_rvalid && i < 64);
    bound;
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // clear the load's counters, then count n cycles
  task meas(input int n);
    @(posedge aclk);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    // one edge past the window: counts read before that edge updates them
    repeat (n + 1) @(posedge aclk);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFF_CONTROL, 32'(CTRL_RESET), RESP_OKAY);
    rd(4'h8, 32'h0, RESP_SLVERR);
    wr(4'h8, 32'hff, 4'h1, RESP_SLVERR);
    wr(OFF_STATUS, 32'hff, 4'h1, RESP_OKAY);
    wr(OFF_CONTROL, 32'h07, 4'h0, RESP_OKAY);
    rd(OFF_CONTROL, 32'h30, RESP_OKAY);
    // fields first, pin drive only afterwards
    wr(OFF_CONTROL, 32'h02, 4'h1, RESP_OKAY);
    meas(2);
    chk(refclk_slew_limit, 1'h0);
    for (dv = 0; dv < 8; dv++) for (dt = 0; dt < 4; dt++) begin
      p = 1 << dv;
      q = p * dt / 4;
      if (dt == 0) q = 0;
      else if (dv == 0) q = 1;
      else if (q < 1) q = 1;
      else if (q > p - 1) q = p - 1;
      wr(OFF_CONTROL, {24'h0, 3'h6, dt[1:0], dv[2:0]}, 4'h1, RESP_OKAY);
      repeat (2 * p + 4) @(posedge aclk);
      meas(8 * p);
      chk(highs, 8 * q);
      chk(mhighs, 8 * q);
      chk(edges, (dt == 0 || dv == 0) ? 0 : 8);
    end
    wr(OFF_CONTROL, 32'hd2, 4'h1, RESP_OKAY);
    rd(OFF_STATUS, 32'h3, RESP_OKAY);
    cpu_cpu_clock_out_disable_n <= 1'h0;
    meas(48);
    chk(edges, 12);
    chk(mhighs, 24);
    rd(OFF_STATUS, 32'h5, RESP_OKAY);
    for (m = 0; m < 3; m++) begin
      {high_speed_crystal_mode, standard_crystal_mode,
        low_power_crystal_mode} <= 3'h1 << m;
      meas(40);
      chk(refclk_out_pin_oe_n, 1'h1);
      chk(mhighs, 20);
      rd(OFF_STATUS, 32'h9, RESP_OKAY);
    end
    {high_speed_crystal_mode, standard_crystal_mode,
      low_power_crystal_mode} <= 3'h0;
    cpu_cpu_clock_out_disable_n <= 1'h1;
    meas(8);
    sleep_active <= 1'h1;
    meas(40);
    chk(edges, 0);
    chk(mhighs % 40, 0);
    rd(OFF_CONTROL, 32'hd2, RESP_OKAY);
    sleep_active <= 1'h0;
    meas(40);
    chk(edges, 10);
    wr(OFF_CONTROL, 32'h50, 4'h1, RESP_OKAY);
    meas(40);
    chk(mhighs, 0);
    wr(OFF_CONTROL, 32'h92, 4'h1, RESP_OKAY);
    meas(40);
    chk(refclk_out_pin_oe_n, 1'h1);
    chk(mhighs, 20);
    // mid-run reset with slew limiting cleared
    aresetn <= 1'h0;
    meas(2);
    aresetn <= 1'h1;
    chk(refclk_slew_limit, 1'h1);
    rd(OFF_CONTROL, 32'h30, RESP_OKAY);
    tally_and_finish;
  end
endmodule
bind rco_top rco_top_sva chk_i (.*);
`default_nettype wire
